// ---- dv/rcm_ctl_model.sv ----
// controller and mark detector stand-in facing the mode control block
module rcm_ctl_model (
  input  wire logic clk_in,
  input  wire logic search_in,
  input  wire logic busy_in,
  output      logic mark_out,
  output      logic nrz_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  initial mark_out = 1'b0;
  initial nrz_out = 1'b0;
  // a mark turns up a few cycles into the search, as on a real track
  always @(posedge clk_in) begin
    cnt <= search_in ? cnt + 1 : 0;
    mark_out <= search_in && cnt == 4;
  end
  // write data held at zero while the header goes out, else toggling
  always @(posedge clk_in) begin
    nrz_out <= busy_in ? 1'b0 : ~nrz_out;
  end
endmodule // rcm_ctl_model

// ---- dv/rcm_mode_ctl_checker.sv ----
// checker: mode decode and read sequence timing at the top ports
module rcm_mode_ctl_checker import rcm_pkg::*; (
  input wire logic CLK_IN, RST_N_IN, WRITE_GATE_IN, READ_GATE_IN,
  input wire logic SERVO_GATE_IN, GLOBAL_SLEEP_PIN_N_IN,
  input wire logic [4:0] BLOCK_OFF_BITS_IN,
  input wire logic GAIN_FREEZE_INPUT_IN, MARK_DETECTED_IN, WRITE_NRZ_IN,
  input wire logic [5:0] MODE_OUT,
  input wire logic [7:0] BLOCK_OFF_REG_OUT,
  input wire logic [4:0] BLOCK_OFF_OUT,
  input wire logic CHANNEL_INIT_OUT, RAW_PULSE_EN_OUT, INPUTS_SHORTED_OUT,
  input wire logic GAIN_FREEZE_OUT, PLL_REF_IS_PULSES_OUT,
  input wire logic RECOVERED_CLK_IS_VCO_OUT, DECODED_DATA_EN_OUT,
  input wire logic MARK_SEARCH_OUT, MARK_FOUND_FLAG_OUT, WRITE_DATA_OUT,
  input wire logic WRITE_HDR_BUSY_OUT, SEQ_ERROR_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  logic rd;
  assign rd = MODE_OUT == MODE_READ;
  a_sleep_all_off: assert property (!GLOBAL_SLEEP_PIN_N_IN |=>
    MODE_OUT == MODE_SLEEP && BLOCK_OFF_OUT == PD_ALL_OFF) else $error("sleep");
  a_wake_init_pulse: assert property ($fell(MODE_OUT[0]) |->
    ##[0:1] CHANNEL_INIT_OUT) else $error("no init after sleep");
  a_read_decode: assert property (!WRITE_GATE_IN && READ_GATE_IN &&
    SERVO_GATE_IN && GLOBAL_SLEEP_PIN_N_IN && BLOCK_OFF_BITS_IN == 5'h00
    |=> rd) else $error("read not entered");
  a_read_front_end: assert property (rd |->
    !RAW_PULSE_EN_OUT && !INPUTS_SHORTED_OUT) else $error("read front end");
  a_read_freeze: assert property (rd |->
    GAIN_FREEZE_OUT == GAIN_FREEZE_INPUT_IN) else $error("freeze ignored");
  a_search_start: assert property ($rose(MODE_OUT[2]) |->
    MARK_SEARCH_OUT) else $error("search not started");
  a_ref_swap_time: assert property ($fell(MARK_SEARCH_OUT) && rd |->
    !PLL_REF_IS_PULSES_OUT [*7] ##[1:4] PLL_REF_IS_PULSES_OUT)
    else $error("reference swap time");
  a_clk_swap_time: assert property ($rose(PLL_REF_IS_PULSES_OUT) |->
    ##[44:52] DECODED_DATA_EN_OUT && RECOVERED_CLK_IS_VCO_OUT)
    else $error("clock swap time");
  a_read_leaves: assert property (rd && !READ_GATE_IN |=> !rd)
    else $error("read kept");
  a_idle_decode: assert property (!WRITE_GATE_IN && !READ_GATE_IN &&
    SERVO_GATE_IN && GLOBAL_SLEEP_PIN_N_IN && BLOCK_OFF_BITS_IN == 5'h00
    |=> MODE_OUT == MODE_IDLE) else $error("idle not entered");
  a_header_busy: assert property ($rose(MODE_OUT[3]) |=>
    WRITE_HDR_BUSY_OUT [*8]) else $error("header not sent");
  a_block_reg_map: assert property (BLOCK_OFF_REG_OUT ==
    {PD_FIXED_HI, BLOCK_OFF_BITS_IN}) else $error("block register map");
  a_servo_pins: assert property (MODE_OUT == MODE_SERVO |->
    !GAIN_FREEZE_OUT && RAW_PULSE_EN_OUT) else $error("servo pins");
  a_ref_after_mark: assert property (MARK_SEARCH_OUT |->
    !PLL_REF_IS_PULSES_OUT) else $error("lock before mark");
endmodule // rcm_mode_ctl_checker
bind rcm_mode_ctl rcm_mode_ctl_checker chk (.*);

// ---- dv/tb.sv ----
// testbench: sleep, read sequence, servo, write header, register map
module tb import rcm_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, wg = 0, rg = 0, sg = 1, slp_n = 1, frz = 0;
  logic [4:0] bits = 5'h00;
  logic [5:0] mode;
  logic [7:0] reg8;
  logic [4:0] boff;
  logic init, raw, shrt, gfz, ref_p, vco, den, srch, flag, wd, busy, serr;
  wire logic mark, nrz;
  int fails = 0, n_tests = 0;
  always #50 clk = ~clk;
  rcm_mode_ctl dut (.CLK_IN(clk), .RST_N_IN(rst_n), .WRITE_GATE_IN(wg),
    .READ_GATE_IN(rg), .SERVO_GATE_IN(sg), .GLOBAL_SLEEP_PIN_N_IN(slp_n),
    .BLOCK_OFF_BITS_IN(bits), .GAIN_FREEZE_INPUT_IN(frz),
    .MARK_DETECTED_IN(mark), .WRITE_NRZ_IN(nrz), .MODE_OUT(mode),
    .BLOCK_OFF_REG_OUT(reg8), .BLOCK_OFF_OUT(boff), .CHANNEL_INIT_OUT(init),
    .RAW_PULSE_EN_OUT(raw), .INPUTS_SHORTED_OUT(shrt), .GAIN_FREEZE_OUT(gfz),
    .PLL_REF_IS_PULSES_OUT(ref_p), .RECOVERED_CLK_IS_VCO_OUT(vco),
    .DECODED_DATA_EN_OUT(den), .MARK_SEARCH_OUT(srch),
    .MARK_FOUND_FLAG_OUT(flag), .WRITE_DATA_OUT(wd),
    .WRITE_HDR_BUSY_OUT(busy), .SEQ_ERROR_OUT(serr));
  rcm_ctl_model ctl (.clk_in(clk), .search_in(srch), .busy_in(busy),
    .mark_out(mark), .nrz_out(nrz));
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic t_sleep();
    logic hit;
    hit = 0;
    rg = 1;
    slp_n = 0;
    step(2);
    chk(mode, MODE_SLEEP);
    chk(boff, PD_ALL_OFF);
    rg = 0; // leaving sleep into idle only, never write
    slp_n = 1;
    repeat (3) begin
      step(1);
      hit |= init;
    end
    chk(hit, 1'b1);
    chk(mode, MODE_IDLE);
    chk({flag, vco}, 2'h2);
    $display("sleep test done");
  endtask
  task automatic t_read();
    int n;
    n = 0;
    rg = 1;
    step(1);
    chk(mode, MODE_READ);
    chk(srch, 1'b1);
    chk({raw, shrt}, 2'h0);
    frz = 1;
    #1 chk(gfz, 1'b1);
    frz = 0;
    chk(ref_p, 1'b0);
    while (!mark && n < 50) begin step(1); n++; end
    n = 0;
    while (!ref_p && n < 20) begin step(1); n++; end
    chk(n >= 8 && n <= 11, 1'b1);
    chk(flag, 1'b1);
    while (!den && n < 80) begin step(1); n++; end
    chk(n >= 55 && n <= 59, 1'b1);
    chk(vco, 1'b1);
    sg = 0;
    step(3);
    chk(mode, MODE_READ);
    rg = 0;
    step(1);
    chk({mode, den}, {MODE_SERVO, 1'b0});
    frz = 1;
    #1 chk({gfz, raw}, 2'h1);
    bits = PD_SERVO2;
    step(2);
    chk(boff, PD_SERVO2);
    bits = 5'h00;
    frz = 0;
    sg = 1;
    step(2);
    $display("read and servo test done");
  endtask
  task automatic t_write();
    logic [88:0] hdr;
    int cnt;
    cnt = 0;
    wg = 1;
    step(1);
    chk({mode, shrt}, {MODE_WRITE, 1'b1});
    for (int i = 0; i < WR_HDR_BITS; i++) begin
      step(1);
      hdr = {hdr[87:0], wd};
      cnt += busy;
    end
    chk(hdr[88:49], MARK_PATTERN);
    chk(hdr[48:9], MARK_PATTERN);
    chk(hdr[8:0], PRE_PATTERN);
    chk(cnt, WR_HDR_BITS);
    chk(serr, 1'b0);
    rg = 1; // both gates high is unlisted, so the mode must hold
    step(2);
    chk(mode, MODE_WRITE);
    {wg, rg} = 2'h0;
    for (int i = 0; i < 5; i++) begin
      bits = 5'h01 << i;
      #1 chk(reg8, {PD_FIXED_HI, bits});
    end
    bits = 5'h00;
    step(2);
    // deliberate illegal wake straight into write must be flagged
    slp_n = 0;
    step(2);
    wg = 1;
    slp_n = 1;
    step(2);
    chk(serr, 1'b1);
    wg = 0;
    step(2);
    $display("write and register test done");
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // generous bound: the whole sequence needs well under 600 cycles
  initial begin
    #(3000 * 100);
    fails++;
    print_verdict();
  end
  initial begin
    step(10);
    rst_n = 1;
    step(2);
    t_sleep();
    t_read();
    t_write();
    print_verdict();
  end
endmodule // tb

// ---- src/rcm_mode_ctl.sv ----
// mode control of the read channel: decode, power, read and write sequence
module rcm_mode_ctl
  import rcm_pkg::*;
#(
  parameter int REF_GRPS = REF_SWAP_GRPS,
  parameter int CLK_GRPS = CLK_SWAP_GRPS
) (
  input  wire logic       CLK_IN,
  input  wire logic       RST_N_IN,
  input  wire logic       WRITE_GATE_IN,
  input  wire logic       READ_GATE_IN,
  input  wire logic       SERVO_GATE_IN,
  input  wire logic       GLOBAL_SLEEP_PIN_N_IN,
  input  wire logic [4:0] BLOCK_OFF_BITS_IN,
  input  wire logic       GAIN_FREEZE_INPUT_IN,
  input  wire logic       MARK_DETECTED_IN,
  input  wire logic       WRITE_NRZ_IN,
  output      logic [5:0] MODE_OUT,
  output      logic [7:0] BLOCK_OFF_REG_OUT,
  output      logic [4:0] BLOCK_OFF_OUT,
  output      logic       CHANNEL_INIT_OUT,
  output      logic       RAW_PULSE_EN_OUT,
  output      logic       INPUTS_SHORTED_OUT,
  output      logic       GAIN_FREEZE_OUT,
  output      logic       PLL_REF_IS_PULSES_OUT,
  output      logic       RECOVERED_CLK_IS_VCO_OUT,
  output      logic       DECODED_DATA_EN_OUT,
  output      logic       MARK_SEARCH_OUT,
  output      logic       MARK_FOUND_FLAG_OUT,
  output      logic       WRITE_DATA_OUT,
  output      logic       WRITE_HDR_BUSY_OUT,
  output      logic       SEQ_ERROR_OUT
);
  localparam int WCW = $clog2(WR_HDR_BITS + 1);
  localparam logic [WCW-1:0] WR_LAST = WCW'(WR_HDR_BITS);
  localparam logic [WCW-1:0] MK_LEN  = WCW'(MARK_BITS);

  // the clock swap must come strictly after the reference swap
  if (REF_GRPS < 1 || CLK_GRPS <= REF_GRPS) begin : g_bad_grps
    $error("rcm_mode_ctl: bad group counts");
  end
  // hdr_bit walks exactly two marks, so other layouts are refused
  if (WR_MARKS != 2 || MARK_BITS != $bits(MARK_PATTERN)
      || PRE_BITS != $bits(PRE_PATTERN)) begin : g_bad_hdr
    $error("rcm_mode_ctl: header layout does not fit hdr_bit");
  end

  rcm_mode_t      mode_q;
  rcm_mode_t      mode_d;
  logic [4:0]     off_q;
  logic [4:0]     off_d;
  logic           init_q;
  logic           err_q;
  logic           wr_q;
  logic           wdat_q;
  logic [WCW-1:0] wcnt_q;
  logic           flag_q;

  rcm_seq_if sif ();

  // header bit generator: marks first, then preamble
  function automatic logic hdr_bit(input logic [WCW-1:0] i);
    logic [WCW-1:0] k;
    k = i;
    if (i < MK_LEN) return MARK_PATTERN[MARK_BITS - 1 - int'(i)];
    if (i < 2 * MK_LEN) begin
      k = i - MK_LEN;
      return MARK_PATTERN[MARK_BITS - 1 - int'(k)];
    end
    k = i - 2 * MK_LEN;
    return PRE_PATTERN[PRE_BITS - 1 - int'(k)];
  endfunction

  // combinational decode, evaluated each cycle
  always_comb begin
    mode_d = mode_q;
    off_d  = off_q;
    if (!GLOBAL_SLEEP_PIN_N_IN) begin
      mode_d = MODE_SLEEP;
      off_d  = PD_ALL_OFF;
    // read holds while the read gate stays high; servo gate is ignored
    end else if (mode_q == MODE_READ && READ_GATE_IN && !WRITE_GATE_IN) begin
      mode_d = MODE_READ;
    end else if (!SERVO_GATE_IN && !WRITE_GATE_IN) begin
      mode_d = MODE_SERVO;
      // only all-on or servo 2 bits apply here, anything else holds powers
      if (BLOCK_OFF_BITS_IN == PD_ALL_ON || BLOCK_OFF_BITS_IN == PD_SERVO2)
        off_d = BLOCK_OFF_BITS_IN;
    end else if (BLOCK_OFF_BITS_IN == PD_ALL_ON && SERVO_GATE_IN) begin
      off_d = PD_ALL_ON;
      unique case ({WRITE_GATE_IN, READ_GATE_IN})
        2'b01:   mode_d = MODE_READ;
        2'b00:   mode_d = MODE_IDLE;
        2'b10:   mode_d = MODE_WRITE;
        default: mode_d = mode_q;
      endcase
    // nonzero bits outside servo: test mode with the bits as written
    end else if (BLOCK_OFF_BITS_IN != PD_ALL_ON) begin
      mode_d = MODE_TEST;
      off_d  = BLOCK_OFF_BITS_IN;
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      mode_q <= MODE_SLEEP;
      off_q  <= PD_ALL_OFF;
    end else begin
      mode_q <= mode_d;
      off_q  <= off_d;
    end
  end

  // wake-up from sleep reinitialises channel state
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      init_q <= 1'b0;
      err_q  <= 1'b0;
    end else begin
      init_q <= mode_q == MODE_SLEEP && mode_d != MODE_SLEEP;
      // illegal wake straight into write is flagged, not blocked
      if (mode_q == MODE_SLEEP && mode_d == MODE_WRITE)
        err_q <= 1'b1;
      else if (mode_d == MODE_SLEEP)
        err_q <= 1'b0;
    end
  end

  assign sif.run       = mode_q == MODE_READ;
  assign sif.init      = init_q;
  // the detector output is already clocked, so no extra flop is spent
  assign sif.mark_seen = MARK_DETECTED_IN;

  rcm_read_seq #(
    .REF_GRPS (REF_GRPS),
    .CLK_GRPS (CLK_GRPS)
  ) u_seq (
    .clk_in   (CLK_IN),
    .rst_n_in (RST_N_IN),
    .sif      (sif)
  );

  // mark flag: high in idle, latched on detection during read
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      flag_q <= 1'b0;
    end else if (mode_q == MODE_IDLE) begin
      flag_q <= 1'b1;
    end else if (mode_q == MODE_READ) begin
      if (sif.searching) flag_q <= MARK_DETECTED_IN;
    end else begin
      flag_q <= 1'b0;
    end
  end

  // write header: the controller holds nrz data at zero meanwhile
  // the counter parks at WR_LAST, one past the last bit, so the header never repeats
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      wr_q   <= 1'b0;
      wcnt_q <= '0;
      wdat_q <= 1'b0;
    end else if (mode_q != MODE_WRITE) begin
      wr_q   <= 1'b0;
      wcnt_q <= '0;
      wdat_q <= 1'b0;
    end else if (wcnt_q != WR_LAST) begin
      wr_q   <= 1'b1;
      wdat_q <= hdr_bit(wcnt_q);
      wcnt_q <= wcnt_q + 1'b1;
    end else begin
      wr_q   <= 1'b0;
      wdat_q <= WRITE_NRZ_IN;
    end
  end

  assign MODE_OUT                 = mode_q;
  assign BLOCK_OFF_OUT            = off_q;
  // combinational so a readback shows new bits without a cycle of lag
  assign BLOCK_OFF_REG_OUT        = {PD_FIXED_HI, BLOCK_OFF_BITS_IN};
  assign CHANNEL_INIT_OUT         = init_q;
  assign RAW_PULSE_EN_OUT         = mode_q == MODE_SERVO
                                 || mode_q == MODE_IDLE;
  assign INPUTS_SHORTED_OUT       = mode_q == MODE_WRITE;
  assign GAIN_FREEZE_OUT          = (mode_q == MODE_READ
                                 || mode_q == MODE_IDLE)
                                 && GAIN_FREEZE_INPUT_IN;
  assign PLL_REF_IS_PULSES_OUT    = sif.ref_is_pulses;
  assign RECOVERED_CLK_IS_VCO_OUT = sif.clk_is_vco;
  assign DECODED_DATA_EN_OUT      = sif.data_en;
  assign MARK_SEARCH_OUT          = sif.searching;
  assign MARK_FOUND_FLAG_OUT      = flag_q;
  assign WRITE_DATA_OUT           = wdat_q;
  assign WRITE_HDR_BUSY_OUT       = wr_q;
  assign SEQ_ERROR_OUT            = err_q;
endmodule : rcm_mode_ctl

// ---- src/rcm_pkg.sv ----
// package: mode codes, bit positions and timing counts for mode control
package rcm_pkg;
  // block power-down register layout
  localparam int          PD_PULSE_BIT  = 0;
  localparam int          PD_SERVO_BIT  = 1;
  localparam int          PD_FILT_BIT   = 2;
  localparam int          PD_SEP_BIT    = 3;
  localparam int          PD_SYNTH_BIT  = 4;
  localparam logic [2:0]  PD_FIXED_HI   = 3'h7;
  localparam logic [4:0]  PD_ALL_ON     = 5'h00;
  localparam logic [4:0]  PD_ALL_OFF    = 5'h1f;
  localparam logic [4:0]  PD_SERVO2     = 5'h18;
  // read sequence timing in 3T groups, one group = 3 synth cycles
  localparam int          T3_CYCLES     = 3;
  localparam int          REF_SWAP_GRPS = 3;
  localparam int          CLK_SWAP_GRPS = 19;
  // write preamble: two marks then three 3T groups
  localparam int          WR_MARKS      = 2;
  localparam int          MARK_BITS     = 40;
  localparam logic [39:0] MARK_PATTERN  = 40'h0080800200;
  localparam int          PRE_BITS      = 9;
  localparam logic [8:0]  PRE_PATTERN   = 9'h124;
  localparam int          WR_HDR_BITS   = WR_MARKS * MARK_BITS + PRE_BITS;

  typedef enum logic [5:0] {
    MODE_SLEEP = 6'h01,
    MODE_IDLE  = 6'h02,
    MODE_READ  = 6'h04,
    MODE_WRITE = 6'h08,
    MODE_SERVO = 6'h10,
    MODE_TEST  = 6'h20
  } rcm_mode_t;

  typedef enum logic [3:0] {
    RS_SEARCH = 4'h1,
    RS_REFSW  = 4'h2,
    RS_LOCK   = 4'h4,
    RS_DATA   = 4'h8
  } rcm_rseq_t;
endpackage : rcm_pkg

// ---- src/rcm_read_seq.sv ----
// read-mode sequencer: mark search, reference swap, clock swap
module rcm_read_seq
  import rcm_pkg::*;
#(
  parameter int REF_GRPS = REF_SWAP_GRPS,
  parameter int CLK_GRPS = CLK_SWAP_GRPS
) (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  rcm_seq_if.seq    sif
);
  localparam int CW = $clog2(CLK_GRPS * T3_CYCLES + 1);
  if (REF_GRPS < 1 || CLK_GRPS <= REF_GRPS) begin : g_bad_grps
    $error("rcm_read_seq: bad group counts");
  end
  localparam logic [CW-1:0] REF_CNT = CW'(REF_GRPS * T3_CYCLES);
  localparam logic [CW-1:0] CLK_CNT = CW'(CLK_GRPS * T3_CYCLES);

  rcm_rseq_t     st_q;
  logic [CW-1:0] cnt_q;

  // counts run from mark detection
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q  <= RS_SEARCH;
      cnt_q <= '0;
    end else if (!sif.run || sif.init) begin
      st_q  <= RS_SEARCH;
      cnt_q <= '0;
    end else begin
      unique case (st_q)
        RS_SEARCH: begin
          cnt_q <= '0;
          if (sif.mark_seen) st_q <= RS_REFSW;
        end
        RS_REFSW: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == REF_CNT - 1'b1) st_q <= RS_LOCK;
        end
        RS_LOCK: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == CLK_CNT - 1'b1) st_q <= RS_DATA;
        end
        RS_DATA: cnt_q <= cnt_q;
      endcase
    end
  end

  assign sif.searching     = sif.run && st_q == RS_SEARCH;
  assign sif.ref_is_pulses = sif.run && (st_q == RS_LOCK || st_q == RS_DATA);
  assign sif.clk_is_vco    = sif.run && st_q == RS_DATA;
  assign sif.data_en       = sif.run && st_q == RS_DATA;
endmodule : rcm_read_seq

// ---- src/rcm_seq_if.sv ----
// interface: read sequencer status between decoder and sequencer
interface rcm_seq_if;
  logic run;
  logic init;
  logic mark_seen;
  logic ref_is_pulses;
  logic clk_is_vco;
  logic data_en;
  logic searching;
  modport ctl (output run, output init, output mark_seen,
               input ref_is_pulses, input clk_is_vco, input data_en,
               input searching);
  modport seq (input run, input init, input mark_seen,
               output ref_is_pulses, output clk_is_vco, output data_en,
               output searching);
endinterface : rcm_seq_if
